// [src/cpc_charger_control.sv]
// Charger parameter registers, mode selection and charge phase sequencer.
`include "cpc_regs.svh"

module cpc_charger_control
	import cpc_pkg::*;
#(
	parameter int unsigned READY_CYCLES = `CPC_READY_MS * 1000 * `CPC_CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire cpc_wr_t wr,
	input wire logic vbus_por,
	input wire logic [12:0] bat_mv,
	input wire logic [9:0] sense_dmv,
	input wire logic die_hot,
	output logic [7:0] setup1,
	output logic [7:0] float_reg,
	output logic [7:0] current_reg,
	output cpc_phase_t phase,
	output cpc_mode_t mode,
	output logic [12:0] float_mv,
	output logic [9:0] charge_limit_dmv,
	output logic [9:0] term_dmv,
	output logic linear_precharge_on,
	output logic switching_on,
	output logic [1:0] stat,
	output logic new_cycle
);
	localparam logic [25:0] READY_LAST = 26'(READY_CYCLES - 1);

	cpc_state_t s;
	cpc_state_t next_s;
	logic trig;
	logic [9:0] target;
	logic [12:0] rech_mv;

	function automatic logic [12:0] float_of(input logic [5:0] code);
		logic [5:0] c;
		c = (code > `CPC_FLOAT_MAX_CODE) ? `CPC_FLOAT_MAX_CODE : code;
		float_of = `CPC_FLOAT_BASE_MV + 13'(c) * `CPC_FLOAT_STEP_MV;
	endfunction : float_of

	function automatic logic [9:0] charge_of(input logic [2:0] code);
		case (code)
			3'h0: charge_of = 10'h176;
			3'h1: charge_of = 10'h1BA;
			3'h2: charge_of = 10'h1FE;
			3'h3: charge_of = 10'h242;
			3'h4: charge_of = 10'h2CA;
			3'h5: charge_of = 10'h30E;
			3'h6: charge_of = 10'h396;
			default: charge_of = 10'h3DA;
		endcase
	endfunction : charge_of

	always_comb begin
		next_s = s;
		trig = 1'b0;
		next_s.new_cycle = 1'b0;
		if (wr.valid) begin
			case (wr.addr)
				`CPC_OFS_SETUP1: begin
					// A 1-to-0 change of disable or high impedance forces a restart; clearing boost also starts a cycle from off.
					if ((s.setup1[`CPC_B_CHG_DIS] && !wr.data[`CPC_B_CHG_DIS]) ||
						(s.setup1[`CPC_B_HIZ] && !wr.data[`CPC_B_HIZ])) begin
						trig = 1'b1;
					end
					next_s.setup1 = wr.data;
				end
				`CPC_OFS_FLOAT: next_s.float_reg = wr.data & `CPC_MASK_FLOAT;
				`CPC_OFS_CURRENT: next_s.current_reg = wr.data & `CPC_MASK_CURRENT;
				default: ;
			endcase
		end
		if (vbus_por) begin
			trig = 1'b1;
		end
		rech_mv = s.float_mv - `CPC_RECHG_MV;
		if (s.phase == CPC_DONE && bat_mv < rech_mv) begin
			trig = 1'b1;
		end
		if (next_s.setup1[`CPC_B_HIZ]) begin
			next_s.mode = CPC_HIZ;
		end else if (next_s.setup1[`CPC_B_BOOST]) begin
			next_s.mode = CPC_BOOST;
		end else begin
			next_s.mode = CPC_CHARGE;
		end
		next_s.float_mv = float_of(next_s.float_reg[7:2]);
		next_s.term_dmv = `CPC_TERM_STEP_DMV * (10'(next_s.current_reg[2:0]) + 10'h001);
		target = charge_of(next_s.current_reg[6:4]);
		if (next_s.mode != CPC_CHARGE || next_s.setup1[`CPC_B_CHG_DIS]) begin
			next_s.phase = CPC_OFF;
		end else if (trig || s.phase == CPC_OFF) begin
			next_s.new_cycle = 1'b1;
			next_s.phase = (bat_mv < `CPC_PRECHG_MV) ? CPC_PRE : CPC_CC;
		end else begin
			case (s.phase)
				CPC_PRE: begin
					if (bat_mv >= `CPC_PRECHG_MV) begin
						next_s.phase = CPC_CC;
					end
				end
				CPC_CC: begin
					if (bat_mv >= s.float_mv) begin
						next_s.phase = CPC_CV;
					end
				end
				CPC_CV: begin
					if (s.setup1[`CPC_B_TERM_EN] && sense_dmv <= s.term_dmv) begin
						next_s.phase = CPC_READY;
						next_s.cnt = '0;
					end
				end
				CPC_READY: begin
					// The wait is spent with switching stopped, before done shows.
					next_s.cnt = s.cnt + 26'h0000001;
					if (s.cnt >= READY_LAST) begin
						next_s.phase = CPC_DONE;
					end
				end
				CPC_DONE: ;
				default: next_s.phase = CPC_OFF;
			endcase
		end
		if (next_s.phase == CPC_CC || next_s.phase == CPC_CV) begin
			if (die_hot) begin
				// No temperature figure is known here, so the loop backs off while hot.
				next_s.cur = (s.cur > `CPC_SLEW_DMV) ? s.cur - `CPC_SLEW_DMV : '0;
			end else if (s.cur > target) begin
				next_s.cur = target;
			end else if (target - s.cur > `CPC_SLEW_DMV) begin
				next_s.cur = s.cur + `CPC_SLEW_DMV;
			end else begin
				next_s.cur = target;
			end
		end else begin
			next_s.cur = '0;
		end
		next_s.pre_on = (next_s.phase == CPC_PRE);
		next_s.pwm_on = (next_s.phase == CPC_CC || next_s.phase == CPC_CV);
		case (next_s.phase)
			CPC_PRE, CPC_CC, CPC_CV: next_s.stat = 2'h1;
			CPC_DONE: next_s.stat = 2'h2;
			default: next_s.stat = 2'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
			s.setup1 <= `CPC_RST_SETUP1;
			s.float_reg <= `CPC_RST_FLOAT;
			s.current_reg <= `CPC_RST_CURRENT;
			s.phase <= CPC_OFF;
			s.mode <= CPC_CHARGE;
			s.float_mv <= 13'h1068;
			s.term_dmv <= `CPC_TERM_STEP_DMV;
		end else begin
			s <= next_s;
		end
	end

	assign setup1 = s.setup1;
	assign float_reg = s.float_reg;
	assign current_reg = s.current_reg;
	assign phase = s.phase;
	assign mode = s.mode;
	assign float_mv = s.float_mv;
	assign charge_limit_dmv = s.cur;
	assign term_dmv = s.term_dmv;
	assign linear_precharge_on = s.pre_on;
	assign switching_on = s.pwm_on;
	assign stat = s.stat;
	assign new_cycle = s.new_cycle;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	AST_FLOAT_LIN: assert property (s.float_reg[7:2] <= 6'h2F |->
		s.float_mv == 13'h0DAC + 13'(s.float_reg[7:2]) * 13'h0014)
		else $error("Float target off the linear code map.");
	AST_FLOAT_SAT: assert property (s.float_reg[7:2] >= 6'h2F |-> s.float_mv == 13'h1158)
		else $error("Float target does not saturate at 4.44 V.");
	AST_WR_CUR: assert property (wr.valid && wr.addr == 8'h04 |=>
		s.current_reg[6:4] == $past(wr.data[6:4]) && s.current_reg[2:0] == $past(wr.data[2:0]))
		else $error("Current codes not taken from the write.");
	AST_TERM: assert property (s.phase == CPC_CV && s.setup1[3] && sense_dmv <= s.term_dmv &&
		!wr.valid && !vbus_por |=> s.phase == CPC_READY)
		else $error("Termination current did not end the voltage phase.");
	AST_TERM_OFF: assert property (s.phase == CPC_CV && !s.setup1[3] && !wr.valid |=>
		s.phase != CPC_READY)
		else $error("Terminated while termination disabled.");
	AST_POR: assert property (vbus_por && !wr.valid && s.mode == CPC_CHARGE && !s.setup1[2] |=>
		s.new_cycle && (s.phase == CPC_PRE || s.phase == CPC_CC))
		else $error("Power-on reset did not start a cycle.");
	AST_PRE: assert property (s.phase == CPC_PRE |-> s.pre_on && !s.pwm_on && s.cur == 10'h000)
		else $error("Switching active during precharge.");
	AST_HIZ: assert property (s.mode != CPC_CHARGE |-> !s.pre_on && !s.pwm_on && s.stat != 2'h1)
		else $error("Charging outside charge mode.");
	AST_HOT: assert property ((die_hot && s.pwm_on && s.cur != 10'h000) ##1 s.pwm_on |->
		s.cur < $past(s.cur))
		else $error("Current not reduced while hot.");
	AST_SLEW: assert property (s.pwm_on ##1 s.pwm_on |-> s.cur <= $past(s.cur) + 10'h00A)
		else $error("Charge current rose too fast.");
	AST_READY: assert property (s.phase == CPC_READY |-> s.stat == 2'h0 && !s.pwm_on ##0
		($past(s.phase) == CPC_CV || $past(s.phase) == CPC_READY))
		else $error("Ready status wrong or entered from the wrong phase.");
	AST_DONE: assert property ($rose(s.phase == CPC_DONE) |-> $past(s.phase) == CPC_READY &&
		$past(s.cnt) >= READY_LAST)
		else $error("Done reached before the ready wait.");
	AST_HOLD: assert property (!wr.valid |=> $stable(s.setup1) && $stable(s.float_reg) &&
		$stable(s.current_reg))
		else $error("Register field changed without a write.");

	// Register fields and derived settings follow a write on the very next edge.
	AST_TERM_LVL: assert property (s.term_dmv ==
		10'h021 * (10'(s.current_reg[2:0]) + 10'h001))
		else $error("Termination level off the code map.");
	AST_WR_SETUP: assert property (wr.valid && wr.addr == 8'h01 |=>
		s.setup1 == $past(wr.data))
		else $error("Setup field not taken from the write.");
	AST_WR_FLOAT: assert property (wr.valid && wr.addr == 8'h02 |=>
		s.float_reg == {$past(wr.data[7:2]), 2'b00})
		else $error("Float code not taken from the write.");
	AST_RSV_ZERO: assert property (!s.current_reg[7] && !s.current_reg[3] &&
		s.float_reg[1:0] == 2'b00)
		else $error("Reserved register bit set.");
	AST_FLOAT_RANGE: assert property (s.float_mv >= 13'h0DAC &&
		s.float_mv <= 13'h1158)
		else $error("Float target outside its range.");
	AST_MODE_HIZ: assert property (s.setup1[1] |->
		s.mode == CPC_HIZ)
		else $error("High impedance request not obeyed.");
	AST_MODE_BOOST: assert property (!s.setup1[1] && s.setup1[0] |->
		s.mode == CPC_BOOST)
		else $error("Boost select not obeyed.");
	AST_MODE_CHG: assert property (!s.setup1[1] && !s.setup1[0] |->
		s.mode == CPC_CHARGE)
		else $error("Charge mode not selected.");
	AST_DIS_OFF: assert property (s.setup1[2] |->
		s.phase == CPC_OFF)
		else $error("Charging while the charger is disabled.");
	AST_ONE_OUT: assert property (!(s.pre_on &&
		s.pwm_on))
		else $error("Linear and switching charge both on.");
	AST_STAT_CHG: assert property (s.pre_on || s.pwm_on |->
		s.stat == 2'h1)
		else $error("Status not charging while charging.");
	AST_CC_ENTRY: assert property (s.phase == CPC_PRE && bat_mv >= 13'h0BB8 &&
		!wr.valid && !vbus_por |=> s.phase == CPC_CC)
		else $error("Precharge did not hand over to constant current.");
	AST_PRE_STAY: assert property (s.phase == CPC_PRE && bat_mv < 13'h0BB8 |=>
		s.phase == CPC_PRE || s.phase == CPC_OFF)
		else $error("Left precharge below the threshold.");
	AST_CV_ENTRY: assert property (s.phase == CPC_CC && bat_mv >= s.float_mv &&
		!wr.valid && !vbus_por |=> s.phase == CPC_CV)
		else $error("Constant current did not hand over to constant voltage.");
	AST_CUR_MAX: assert property (s.cur <=
		10'h3DA)
		else $error("Charge current above the largest target.");
	AST_CUR_IDLE: assert property (!s.pwm_on |->
		s.cur == 10'h000)
		else $error("Charge current without switching.");
	AST_HOT_NOUP: assert property (die_hot && s.pwm_on |=>
		s.cur <= $past(s.cur))
		else $error("Charge current rose while hot.");
	AST_RECHG: assert property (s.phase == CPC_DONE && bat_mv < s.float_mv - 13'h0078 &&
		!wr.valid |=> s.new_cycle)
		else $error("Recharge dip did not start a cycle.");
	AST_WR_RESTART: assert property (wr.valid && wr.addr == 8'h01 && s.setup1[1] &&
		wr.data[2:0] == 3'h0 |=> s.new_cycle)
		else $error("Leaving high impedance did not start a cycle.");
	AST_EN_RESTART: assert property (wr.valid && wr.addr == 8'h01 && s.setup1[2] &&
		wr.data[2:0] == 3'h0 |=> s.new_cycle)
		else $error("Enabling the charger did not start a cycle.");
	AST_NEWC: assert property (s.new_cycle |->
		s.phase == CPC_PRE || s.phase == CPC_CC)
		else $error("Cycle start outside a charging phase.");
	AST_DONE_STAT: assert property (s.phase == CPC_DONE |->
		s.stat == 2'h2 && !s.pwm_on)
		else $error("Done status wrong.");

	COV_DONE: cover property (s.phase == CPC_READY ##1 s.phase == CPC_DONE);
	COV_HOT: cover property (die_hot && s.pwm_on && s.cur != 10'h000);
	COV_WR_RESTART: cover property (wr.valid && wr.addr == 8'h01 && s.setup1[1] && !wr.data[1]);
	COV_RECHARGE: cover property (s.phase == CPC_DONE ##1 s.new_cycle);
	COV_TERM_HELD: cover property (s.phase == CPC_CV && !s.setup1[3] && sense_dmv <= s.term_dmv);
endmodule : cpc_charger_control

// [src/cpc_pkg.sv]
// Types shared by the charger controller.
package cpc_pkg;
	typedef enum logic [2:0] {CPC_OFF, CPC_PRE, CPC_CC, CPC_CV, CPC_READY, CPC_DONE} cpc_phase_t;
	typedef enum logic [1:0] {CPC_CHARGE, CPC_BOOST, CPC_HIZ} cpc_mode_t;
	typedef struct packed {
		logic valid;
		logic [7:0] addr;
		logic [7:0] data;
	} cpc_wr_t;
	typedef struct packed {
		logic [7:0] setup1;
		logic [7:0] float_reg;
		logic [7:0] current_reg;
		cpc_phase_t phase;
		cpc_mode_t mode;
		logic [9:0] cur;
		logic [25:0] cnt;
		logic [12:0] float_mv;
		logic [9:0] term_dmv;
		logic pre_on;
		logic pwm_on;
		logic [1:0] stat;
		logic new_cycle;
	} cpc_state_t;
endpackage : cpc_pkg

// [src/cpc_regs.svh]
// Register offsets, field positions, reset values and timing counts of the charger controller.
`ifndef CPC_REGS_SVH
`define CPC_REGS_SVH
`define CPC_OFS_SETUP1 8'h01
`define CPC_OFS_FLOAT 8'h02
`define CPC_OFS_CURRENT 8'h04
`define CPC_B_TERM_EN 3
`define CPC_B_CHG_DIS 2
`define CPC_B_HIZ 1
`define CPC_B_BOOST 0
`define CPC_RST_SETUP1 8'h38
`define CPC_RST_FLOAT 8'h8C
`define CPC_RST_CURRENT 8'h00
`define CPC_MASK_FLOAT 8'hFC
`define CPC_MASK_CURRENT 8'h77
`define CPC_FLOAT_BASE_MV 13'h0DAC
`define CPC_FLOAT_STEP_MV 13'h0014
`define CPC_FLOAT_MAX_CODE 6'h2F
`define CPC_TERM_STEP_DMV 10'h021
`define CPC_PRECHG_MV 13'h0BB8
`define CPC_RECHG_MV 13'h0078
`define CPC_SLEW_DMV 10'h00A
`define CPC_CLK_MHZ 100
`define CPC_READY_MS 500
`endif

// [test/cpc_charger_control_bench.sv]
// Self-checking bench for the charger controller.
module cpc_charger_control_bench
	import cpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rst_b = 0, vbus_por = 0, die_hot = 0, seen = 0;
	logic [12:0] bat_mv = 13'h0E74;
	logic [9:0] sense_dmv = 10'h3FF;
	cpc_wr_t wr;
	logic [7:0] setup1, float_reg, current_reg;
	cpc_phase_t phase;
	cpc_mode_t mode;
	logic [12:0] float_mv;
	logic [9:0] lim, term_dmv, a;
	logic lin_on, sw_on, new_cycle;
	logic [1:0] stat;
	int fail_count = 0, comparisons = 0, cycles = 0, i;
	always #5 sys_clk = ~sys_clk;
	cpc_host_model u_host (.sys_clk(sys_clk), .wr(wr));
	cpc_charger_control #(.READY_CYCLES(8)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.wr(wr), .vbus_por(vbus_por), .bat_mv(bat_mv), .sense_dmv(sense_dmv),
		.die_hot(die_hot), .setup1(setup1), .float_reg(float_reg),
		.current_reg(current_reg), .phase(phase), .mode(mode), .float_mv(float_mv),
		.charge_limit_dmv(lim), .term_dmv(term_dmv), .linear_precharge_on(lin_on),
		.switching_on(sw_on), .stat(stat), .new_cycle(new_cycle));
	task automatic report_and_stop;
		if (fail_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_phase(input cpc_phase_t p);
		int n;
		for (n = 0; n < 100 && phase !== p; n++)
			@(negedge sys_clk);
	endtask : wait_phase
	// The pulse is one cycle wide, so a sticky flag catches it whatever its exact edge.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (new_cycle === 1'b1)
			seen <= 1'b1;
		if (cycles == 6000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (16) @(negedge sys_clk);
		chk(setup1, 8'h38);
		chk(float_reg, 8'h8C);
		chk(current_reg, 8'h00);
		chk(float_mv, 13'h1068);
		chk(term_dmv, 10'h021);
		rst_b = 1;
		wait_phase(CPC_CC);
		chk(sw_on, 1'b1);
		a = lim;
		@(negedge sys_clk);
		chk(lim, a + 10'h00A);
		die_hot = 1;
		@(negedge sys_clk);
		a = lim;
		@(negedge sys_clk);
		chk(lim, a - 10'h00A);
		die_hot = 0;
		bat_mv = 13'h0AF0;
		seen = 0;
		vbus_por = 1;
		@(negedge sys_clk);
		vbus_por = 0;
		wait_phase(CPC_PRE);
		@(negedge sys_clk);
		chk(seen, 1'b1);
		chk(lin_on, 1'b1);
		chk(sw_on, 1'b0);
		bat_mv = 13'h0BB8;
		wait_phase(CPC_CC);
		chk(phase, CPC_CC);
		for (i = 0; i < 64; i++) begin
			u_host.write(8'h02, {i[5:0], 2'b11});
			chk(float_reg, {i[5:0], 2'b00});
			chk(float_mv, 16'(3500 + 20 * (i > 47 ? 47 : i)));
		end
		for (i = 0; i < 8; i++) begin
			u_host.write(8'h04, {1'b1, i[2:0], 1'b1, i[2:0]});
			chk(current_reg, {1'b0, i[2:0], 1'b0, i[2:0]});
			chk(term_dmv, 16'(33 * (i + 1)));
		end
		u_host.write(8'h02, 8'h8C);
		u_host.write(8'h01, 8'hF8);
		chk(setup1, 8'hF8);
		u_host.write(8'h03, 8'h00);
		chk(setup1, 8'hF8);
		u_host.write(8'h04, 8'h70);
		repeat (70) @(negedge sys_clk);
		u_host.write(8'h04, 8'h00);
		@(negedge sys_clk);
		chk(lim, 10'd374);
		u_host.write(8'h01, 8'hF9);
		chk(mode, CPC_BOOST);
		u_host.write(8'h01, 8'hFB);
		chk(mode, CPC_HIZ);
		repeat (2) @(negedge sys_clk);
		chk(phase, CPC_OFF);
		bat_mv = 13'h0E74;
		seen = 0;
		u_host.write(8'h01, 8'hF8);
		repeat (2) @(negedge sys_clk);
		chk(seen, 1'b1);
		chk(mode, CPC_CHARGE);
		u_host.write(8'h01, 8'hFC);
		seen = 0;
		u_host.write(8'h01, 8'hF0);
		repeat (2) @(negedge sys_clk);
		chk(seen, 1'b1);
		bat_mv = 13'h1068;
		sense_dmv = 10'h014;
		wait_phase(CPC_CV);
		repeat (20) @(negedge sys_clk);
		chk(phase, CPC_CV);
		u_host.write(8'h01, 8'hF8);
		wait_phase(CPC_READY);
		chk(stat, 2'b00);
		chk(sw_on, 1'b0);
		repeat (6) @(negedge sys_clk);
		chk(phase, CPC_READY);
		repeat (4) @(negedge sys_clk);
		chk(stat, 2'b10);
		seen = 0;
		bat_mv = 13'h0FF0;
		repeat (4) @(negedge sys_clk);
		chk(phase, CPC_DONE);
		bat_mv = 13'h0FEF;
		repeat (3) @(negedge sys_clk);
		chk(seen, 1'b1);
		report_and_stop();
	end
endmodule : cpc_charger_control_bench

// [test/cpc_host_model.sv]
// Host model that issues register writes as the serial decoder would.
module cpc_host_model
	import cpc_pkg::*;
(
	input wire logic sys_clk,
	output cpc_wr_t wr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial wr = '0;
	// A full idle cycle follows each strobe, so two writes never merge.
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		wr <= '{1'b1, a, d};
		@(negedge sys_clk);
		wr <= '0;
	endtask : write
endmodule : cpc_host_model
